/* shared/oss_pkg.sv */
// Constants shared by the octal switch serial control port
package oss_pkg;
  localparam int unsigned CHANNELS = 8;
  // AXI4-Lite register byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  // Field positions inside the status register
  localparam int unsigned STAT_OV_BIT = 8;
  localparam int unsigned STAT_ARMED_BIT = 9;
  localparam int unsigned STAT_SEL_BIT = 10;
  localparam int unsigned STAT_SPD_BIT = 11;
  // Reset values
  localparam logic [7:0] CMD_ALL_OFF = 8'hff;
  localparam logic [7:0] SHIFT_CLEAR = 8'h00;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Fault delay timer after select rise
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned FAULT_DELAY_US = 100;
  localparam int unsigned FAULT_DELAY_CYC = FAULT_DELAY_US * CLK_MHZ;
endpackage

/* shared/oss_pins_if.sv */
// Synchronised serial pin levels passed from the sampler to the core
`timescale 1ns/100ps
interface oss_pins_if;
  logic sel_n;
  logic sclk;
  logic sdi;
  modport src (output sel_n, output sclk, output sdi);
  modport dst (input sel_n, input sclk, input sdi);
endinterface

/* rtl/oss_sync.sv */
// Two-flop synchroniser for the serial pins
`timescale 1ns/100ps
module oss_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Raw pins
  input wire logic sel_n_pin,
  input wire logic sclk_pin,
  input wire logic sdi_pin,
  // Synchronised levels
  oss_pins_if.src pins
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= 3'h1;
      sync_q <= 3'h1;
    end
    else
    begin
      meta_q <= {sdi_pin, sclk_pin, sel_n_pin};
      sync_q <= meta_q;
    end
  end

  assign pins.sel_n = sync_q[0];
  assign pins.sclk = sync_q[1];
  assign pins.sdi = sync_q[2];
endmodule

/* rtl/oss_top.sv */
// Serial control port of an eight-channel low-side switch with AXI4-Lite mirror
// Contract
// R1 - Serial transfers happen only while select is low.
// R2 - Select rising copies the shift register into the switch controls.
// R3 - Select falling loads present drain states into the shift register.
// R4 - Serial output driver enabled when select goes low, otherwise high impedance.
// R5 - Serial input sampled into shift register on serial clock falling edge.
// R6 - Serial output advances on serial clock rising edge.
// R7 - Host keeps serial clock low during select transitions.
// R8 - Host should keep serial clock low while deselected.
// R9 - While deselected, clock and data ignored, output high impedance.
// R10 - Command one means OFF, zero means ON, applied at select rise.
// R11 - Frame is eight bits, MSB first, first bit is output 7.
// R12 - Host keeps serial input stable around serial clock rise.
// R13 - Status bit high for OFF unfaulted, low for ON unfaulted.
// R14 - Returned status reflects previously latched command.
// R15 - Command and status both shift MSB first, first status bit output 7.
// R16 - Clear input does not affect the serial output.
// R17 - Clear low empties the shift register and forces all outputs OFF.
// R18 - Host holds clear low at power-up until supplies are adequate.
// R19 - Host holds clear low at least 250 ns per reset.
// R20 - Host should assert clear after a load supply dip.
// R21 - Strap high keeps shorted output ON in current limit.
// R22 - Strap low latches off only the shorted output.
// R23 - After over-voltage shutdown next status word is all ones.
// R24 - Select rise starts fault delay timer; detection disabled until expiry.
// R25 - Latched-off output stays OFF until a later command requests ON.
// R26 - Plain eight-stage shifter; only last eight bits latched.
`timescale 1ns/100ps
module oss_top
  import oss_pkg::*;
#(
  parameter int unsigned FAULT_DELAY = FAULT_DELAY_CYC
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Serial link pins
  input wire logic SEL_N,
  input wire logic SCLK,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  // Device pins
  input wire logic CLEAR_N,
  input wire logic SHORT_PROTECT_DISABLE,
  input wire logic LOAD_SUPPLY_OV,
  input wire logic [CHANNELS-1:0] SHORT_DET,
  input wire logic [CHANNELS-1:0] THERMAL_DET,
  output logic [CHANNELS-1:0] SWITCH_OFF,
  // AXI4-Lite write channels
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read channels
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  oss_pins_if pins ();
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic sel_n_prev_q;
  logic sclk_prev_q;

  initial
  begin
    if (CHANNELS != 8 || FAULT_DELAY < 1)
      $error("Unsupported oss_top parameters");
  end

  oss_sync u_sync
  (
    .clk(CLK),
    .reset_n(RESET_N),
    .sel_n_pin(SEL_N),
    .sclk_pin(SCLK),
    .sdi_pin(SDI),
    .pins(pins)
  );

  // Clear, strap and supply are also foreign levels
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      meta_q <= 5'h01;
      sync_q <= 5'h01;
    end
    else
    begin
      meta_q <= {1'b0, 1'b0, LOAD_SUPPLY_OV, SHORT_PROTECT_DISABLE, CLEAR_N};
      sync_q <= meta_q;
    end
  end

  // Per-output sense lines come from the analog side, so they are foreign too
  logic [2*CHANNELS-1:0] det_meta_q;
  logic [2*CHANNELS-1:0] det_sync_q;
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      det_meta_q <= '0;
      det_sync_q <= '0;
    end
    else
    begin
      det_meta_q <= {THERMAL_DET, SHORT_DET};
      det_sync_q <= det_meta_q;
    end
  end

  logic [CHANNELS-1:0] short_s;
  logic [CHANNELS-1:0] therm_s;
  assign short_s = det_sync_q[CHANNELS-1:0];
  assign therm_s = det_sync_q[2*CHANNELS-1:CHANNELS];

  logic clear_n_s;
  logic spd_s;
  logic ov_s;
  assign clear_n_s = sync_q[0];
  assign spd_s = sync_q[1];
  assign ov_s = sync_q[2];

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sel_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      sel_n_prev_q <= pins.sel_n;
      sclk_prev_q <= pins.sclk;
    end
  end

  logic sel_fall;
  logic sel_rise;
  logic sclk_fall;
  logic sclk_rise;
  // Clock edges only count while selected
  assign sel_fall = sel_n_prev_q && !pins.sel_n;
  assign sel_rise = !sel_n_prev_q && pins.sel_n;
  assign sclk_fall = !pins.sel_n && !sel_n_prev_q && sclk_prev_q && !pins.sclk; // see R1 see R9
  assign sclk_rise = !pins.sel_n && !sel_n_prev_q && !sclk_prev_q && pins.sclk; // see R9

  // ----------------------------------------------------------------
  // Shift register and serial output
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] shift_q;
  logic [CHANNELS-1:0] cmd_q;
  logic [CHANNELS-1:0] drain_off;
  logic sdo_q;
  logic sdo_oe_q;
  logic ov_latch_q;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      shift_q <= SHIFT_CLEAR;
    else if (!clear_n_s)
      shift_q <= SHIFT_CLEAR; // see R17
    else if (sel_fall)
      shift_q <= drain_off; // see R3 see R13 see R14
    else if (sclk_fall)
      shift_q <= {shift_q[CHANNELS-2:0], pins.sdi}; // see R5 see R11 see R15 see R26
  end

  // Output pin follows the MSB; clear deliberately not involved
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end
    else
    begin
      sdo_oe_q <= !pins.sel_n; // see R4 see R9 see R16
      if (sel_fall)
        sdo_q <= drain_off[CHANNELS-1]; // see R15
      else if (sclk_rise)
        sdo_q <= shift_q[CHANNELS-1]; // see R6
    end
  end

  // ----------------------------------------------------------------
  // Command latch, over-voltage and faults
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] fault_off_q;
  logic [$clog2(FAULT_DELAY+1)-1:0] delay_q;
  logic armed;
  assign armed = (delay_q == '0);

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      cmd_q <= CMD_ALL_OFF;
    else if (!clear_n_s || ov_s)
      cmd_q <= CMD_ALL_OFF; // see R17
    else if (sel_rise)
      cmd_q <= shift_q; // see R2 see R10
  end

  // Over-voltage forces OFF until reprogrammed after it ends
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      ov_latch_q <= 1'b0;
    else if (ov_s)
      ov_latch_q <= 1'b1;
    else if (sel_rise)
      ov_latch_q <= 1'b0;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      delay_q <= '0;
    else if (sel_rise)
      delay_q <= ($clog2(FAULT_DELAY+1))'(FAULT_DELAY); // see R24
    else if (!armed)
      delay_q <= delay_q - 1'b1;
  end

  // Latch-off clears only when a new command asks for ON again
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      fault_off_q <= '0;
    else
      for (int i = 0; i < CHANNELS; i++)
      begin
        if (armed && !spd_s && short_s[i] && !cmd_q[i])
          fault_off_q[i] <= 1'b1; // see R22
        else if (sel_rise && !shift_q[i])
          fault_off_q[i] <= 1'b0; // see R25
      end
  end

  // Strap high: short stays ON in current limit; thermal still turns off
  assign drain_off = cmd_q | fault_off_q | therm_s | {CHANNELS{ov_latch_q}}; // see R21 see R23

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      SWITCH_OFF <= CMD_ALL_OFF;
    else
      SWITCH_OFF <= drain_off;
  end

  assign SDO = sdo_q;
  assign SDO_OE = sdo_oe_q;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_q;
  logic w_q;
  logic wrdy_q;
  logic arready_q;
  logic [7:0] awaddr_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && !aw_q && !bvalid_q)
      begin
        aw_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_q && !bvalid_q)
        w_q <= 1'b1;
      if (wrdy_q)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q == ADDR_FAULT) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && S_AXI_BREADY)
        bvalid_q <= 1'b0;
    end
  end

  // Ready is a registered pulse once both halves are held
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      wrdy_q <= 1'b0;
    else
      wrdy_q <= aw_q && w_q && !wrdy_q;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      arready_q <= 1'b0;
    else
      arready_q <= S_AXI_ARVALID && !rvalid_q && !arready_q;
  end

  // Writes only arm the software fault-injection mask; serial owns the command
  logic [CHANNELS-1:0] inject_q;
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      inject_q <= '0;
    else if (wrdy_q && awaddr_q == ADDR_FAULT && S_AXI_WSTRB[0])
      inject_q <= S_AXI_WDATA[CHANNELS-1:0];
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
      case (S_AXI_ARADDR)
        ADDR_CMD: rdata_q[CHANNELS-1:0] <= cmd_q;
        ADDR_STAT:
        begin
          rdata_q[CHANNELS-1:0] <= drain_off;
          rdata_q[STAT_OV_BIT] <= ov_latch_q;
          rdata_q[STAT_ARMED_BIT] <= armed;
          rdata_q[STAT_SEL_BIT] <= !pins.sel_n;
          rdata_q[STAT_SPD_BIT] <= spd_s;
        end
        ADDR_FAULT: rdata_q[CHANNELS-1:0] <= fault_off_q | inject_q;
        default: rresp_q <= RESP_SLVERR;
      endcase
    end
    else if (rvalid_q && S_AXI_RREADY)
      rvalid_q <= 1'b0;
  end

  assign S_AXI_AWREADY = wrdy_q;
  assign S_AXI_WREADY = wrdy_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
endmodule

/* sim/oss_chk.sv */
// Pin-level assertions for the octal switch serial port
`timescale 1ns/100ps
module oss_chk
  import oss_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Serial pins
  input wire logic SEL_N,
  input wire logic SCLK,
  input wire logic SDO,
  input wire logic SDO_OE,
  // Device pins
  input wire logic CLEAR_N,
  input wire logic SHORT_PROTECT_DISABLE,
  input wire logic LOAD_SUPPLY_OV,
  input wire logic [CHANNELS-1:0] SHORT_DET,
  input wire logic [CHANNELS-1:0] THERMAL_DET,
  input wire logic [CHANNELS-1:0] SWITCH_OFF,
  // Bus
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_BVALID
);
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic quiet;
  // Nothing that may legally move the outputs
  assign quiet = SEL_N && CLEAR_N && !LOAD_SUPPLY_OV && THERMAL_DET == 8'h00
    && (SHORT_PROTECT_DISABLE || SHORT_DET == 8'h00);
  chk_oe_on_sel: assert property ($fell(SEL_N) |-> ##[1:6] SDO_OE)
    else $error("driver not enabled");
  chk_oe_while_sel: assert property (!SEL_N [*8] |-> SDO_OE)
    else $error("driver dropped");
  chk_oe_idle: assert property (SEL_N [*8] |-> !SDO_OE)
    else $error("driver on while idle");
  chk_sdo_rise_only: assert property ((!SCLK && !SEL_N) [*6] |=> $stable(SDO))
    else $error("serial out moved");
  chk_clear_all_off: assert property (!CLEAR_N [*6] |-> SWITCH_OFF == 8'hff)
    else $error("clear left output on");
  chk_ov_all_off: assert property (LOAD_SUPPLY_OV [*6] |-> SWITCH_OFF == 8'hff)
    else $error("overvoltage left output on");
  chk_desel_hold: assert property (quiet [*8] |=> $stable(SWITCH_OFF))
    else $error("outputs moved while idle");
  chk_b_after_w: assert property (S_AXI_AWREADY |=> S_AXI_BVALID)
    else $error("no write response");
  cover property ($rose(SEL_N));
  cover property (!CLEAR_N && !SEL_N);
  cover property (S_AXI_BVALID);
endmodule

/* sim/oss_host.sv */
// Serial bus master model
`timescale 1ns/100ps
module oss_host
(
  // Clock
  input wire logic clk,
  // Serial pins
  output logic sel_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  initial
  begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Slack either side lets the synchroniser settle
  task sel(input logic v);
    repeat (8) @(posedge clk);
    sel_n <= v;
    repeat (8) @(posedge clk);
    if (v) sdi <= ~sdi;
  endtask
  // Data set well before the rise, read back after the fall
  task bitx(input logic b, output logic o);
    sdi <= b;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
    sclk <= 1'b0;
    repeat (2) @(posedge clk);
    o = sdo;
    repeat (2) @(posedge clk);
  endtask
  task noise(input logic [1:0] v);
    @(posedge clk);
    sclk <= v[0];
    sdi <= v[1];
  endtask
endmodule

/* sim/oss_top_tb.sv */
// Self-checking bench for the octal switch serial port
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module oss_top_tb
  import oss_pkg::*;
();
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic sel_n, sclk, sdi, sdo, sdo_oe, awready, wready, bvalid, arready, rvalid;
  logic clear_n = 1'b0;
  logic spd = 1'b0;
  logic ov = 1'b0;
  logic [7:0] sdet = 8'h00, tdet = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [7:0] switch_off, c, s, prev, m;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0] bresp, rresp, r;
  logic [9:0] v;
  int mismatches = 0;
  int num_checks = 0;
  integer seed = 32'he0e2;
  initial
  begin
    forever #5 clk = ~clk;
  end
  oss_host h (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
  oss_top #(.FAULT_DELAY(20)) uut (.CLK(clk), .RESET_N(reset_n), .SEL_N(sel_n), .SCLK(sclk), .SDI(sdi),
    .SDO(sdo), .SDO_OE(sdo_oe), .CLEAR_N(clear_n), .SHORT_PROTECT_DISABLE(spd), .LOAD_SUPPLY_OV(ov),
    .SHORT_DET(sdet), .THERMAL_DET(tdet), .SWITCH_OFF(switch_off), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic logic [7:0] drain(input logic [7:0] cmd, input logic [7:0] off);
    return cmd | off;
  endfunction
  task automatic frame(input logic [7:0] cmd, output logic [7:0] st);
    h.sel(1'b0);
    for (int i = 7; i >= 0; i--)
      h.bitx(cmd[i], st[i]);
    h.sel(1'b1);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat, input logic [3:0] ws,
    output logic [1:0] rsp);
    @(posedge clk);
    awaddr <= a;
    wdata <= dat;
    wstrb <= ws;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    dat = rdata;
    rsp = rresp;
    arvalid <= 1'b0;
    rready <= 1'b0;
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    clear_n <= 1'b1;
    prev = CMD_ALL_OFF;
    for (int k = 0; k < 8; k++)
    begin
      c = (k == 0) ? 8'h00 : (k == 1) ? 8'ha5 : 8'($random(seed));
      frame(c, s);
      `CHK(s, prev)
      `CHK(switch_off, c)
      axi_rd(ADDR_CMD, d, r);
      `CHK(d[7:0], c)
      prev = c;
    end
    v = 10'($random(seed));
    h.sel(1'b0);
    for (int i = 9; i >= 0; i--)
      h.bitx(v[i], s[0]);
    h.sel(1'b1);
    `CHK(switch_off, v[7:0])
    repeat (30) h.noise(2'($random(seed)));
    h.noise(2'b00);
    repeat (8) @(posedge clk);
    `CHK(switch_off, v[7:0])
    frame(8'h5a, s);
    h.sel(1'b0);
    clear_n <= 1'b0;
    repeat (30) @(posedge clk);
    `CHK(sdo_oe, 1'b1)
    `CHK(switch_off, CMD_ALL_OFF)
    clear_n <= 1'b1;
    h.sel(1'b1);
    `CHK(switch_off, SHIFT_CLEAR)
    repeat (30) @(posedge clk);
    m = 8'h01 << 3'($random(seed));
    sdet <= m;
    repeat (10) @(posedge clk);
    sdet <= 8'h00;
    repeat (10) @(posedge clk);
    `CHK(switch_off, drain(8'h00, m))
    frame(8'h00, s);
    `CHK(s, m)
    sdet <= 8'h01;
    repeat (6) @(posedge clk);
    sdet <= 8'h00;
    repeat (6) @(posedge clk);
    `CHK(switch_off, 8'h00)
    spd <= 1'b1;
    repeat (30) @(posedge clk);
    sdet <= 8'h10;
    repeat (10) @(posedge clk);
    `CHK(switch_off, 8'h00)
    sdet <= 8'h00;
    spd <= 1'b0;
    m = 8'h01 << 3'($random(seed));
    tdet <= m;
    frame(8'h00, s);
    `CHK(s, drain(8'h00, m))
    tdet <= 8'h00;
    ov <= 1'b1;
    repeat (10) @(posedge clk);
    ov <= 1'b0;
    frame(8'h00, s);
    `CHK(s, CMD_ALL_OFF)
    c = 8'($random(seed));
    axi_wr(ADDR_FAULT, {24'h0, c}, 4'hf, r);
    `CHK(r, RESP_OKAY)
    axi_rd(ADDR_FAULT, d, r);
    `CHK(d[7:0], c)
    axi_wr(ADDR_FAULT, {24'h0, ~c}, 4'he, r);
    `CHK(r, RESP_OKAY)
    axi_rd(ADDR_FAULT, d, r);
    `CHK(d[7:0], c)
    axi_wr(ADDR_CMD, 32'h1, 4'hf, r);
    `CHK(r, RESP_SLVERR)
    axi_rd(8'h0c, d, r);
    `CHK({d, r}, {32'h0, RESP_SLVERR})
    test_done;
  end
  // Run is near 2000 cycles; this cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done;
  end
endmodule
bind oss_top oss_chk chk_i (.CLK(CLK), .RESET_N(RESET_N), .SEL_N(SEL_N), .SCLK(SCLK), .SDO(SDO),
  .SDO_OE(SDO_OE), .CLEAR_N(CLEAR_N), .SHORT_PROTECT_DISABLE(SHORT_PROTECT_DISABLE),
  .LOAD_SUPPLY_OV(LOAD_SUPPLY_OV), .SHORT_DET(SHORT_DET), .THERMAL_DET(THERMAL_DET),
  .SWITCH_OFF(SWITCH_OFF), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BVALID(S_AXI_BVALID));
